/* hdl/hsr_defines.svh */
/*
 * Constants of the hot-swap fault and reset controller: register offsets,
 * status field positions, reset values and timing counts.
 * Assumes a 100 ns timing clock; counts are derived from that period.
 */
`ifndef HSR_DEFINES_SVH
`define HSR_DEFINES_SVH

`define HSR_CLK_PERIOD_NS    100
`define HSR_MIN_PULSE_NS     5000
`define HSR_MIN_PULSE_CYC    ((`HSR_MIN_PULSE_NS + `HSR_CLK_PERIOD_NS - 1) / `HSR_CLK_PERIOD_NS)
`define HSR_OC_FILTER_NS     5000
`define HSR_OC_FILTER_CYC    ((`HSR_OC_FILTER_NS + `HSR_CLK_PERIOD_NS - 1) / `HSR_CLK_PERIOD_NS)
`define HSR_RETRY_DELAY_MS   100
`define HSR_RETRY_DELAY_CYC  (`HSR_RETRY_DELAY_MS * 1000000 / `HSR_CLK_PERIOD_NS)

`define HSR_RETRY_LIMIT_DEF  3'h5
`define HSR_RESET_DELAY_DEF  16'h03E8

`define HSR_REG_RESET_DELAY  32'h0000_0000
`define HSR_REG_RETRY_LIMIT  32'h0000_0004
`define HSR_REG_STATUS       32'h0000_0008

`define HSR_ST_GATE          0
`define HSR_ST_PWR_GOOD      1
`define HSR_ST_SYS_RESET_N   2
`define HSR_ST_FAILURE       3
`define HSR_ST_BATT_SEL      4
`define HSR_ST_OV            5
`define HSR_ST_UV            6
`define HSR_ST_OC            7
`define HSR_ST_IGATE_LSB     8
`define HSR_ST_RETRY_LSB     12
`define HSR_ST_STATE_LSB     16

`define HSR_RESP_OKAY        2'h0
`define HSR_RESP_SLVERR      2'h2

`endif

/* hdl/hsr_pkg.sv */
/*
 * Types of the hot-swap fault and reset controller: state and gate current
 * encodings, AXI4-Lite request and response bundles, comparator bundle.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package hsr_pkg;

   typedef enum logic [3:0] {
      HSR_GATE_HOLD = 4'h1,
      HSR_GATE_ON   = 4'h2,
      HSR_GATE_WAIT = 4'h4,
      HSR_GATE_FAIL = 4'h8
   } hsr_gate_state_e;

   typedef enum logic [1:0] {
      HSR_IGATE_50UA  = 2'h0,
      HSR_IGATE_10UA  = 2'h1,
      HSR_IGATE_70UA  = 2'h2,
      HSR_IGATE_150UA = 2'h3
   } hsr_igate_e;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } hsr_axi_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } hsr_axi_rsp_s;

   typedef struct packed {
      logic overvoltage_trip;
      logic mains_undervoltage_trip;
      logic battery_undervoltage_trip;
      logic overcurrent_trip;
   } hsr_comp_s;

endpackage

/* hdl/hsr_sync.sv */
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes the inputs may change at any time relative to clock.
 */
module hsr_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset_n,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   if (WIDTH < 1) begin : g_check
      $error("hsr_sync: WIDTH must be at least 1");
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            meta <= 1'b0;
            q[i] <= 1'b0;
         end else begin
            meta <= d[i];
            q[i] <= meta;
         end
      end
   end

endmodule // hsr_sync

/* hdl/hsr_pulse_qual.sv */
/*
 * Minimum-width qualifier: output rises once the input has been high for
 * MIN_CYC consecutive clocks and falls with the input.
 * Assumes a synchronous input.
 */
module hsr_pulse_qual #(
   parameter int MIN_CYC = 50
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // Level in, qualified level out
   input  wire logic active,
   output logic      qualified
);

   localparam int CW = $clog2(MIN_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(MIN_CYC - 1);

   if (MIN_CYC < 1) begin : g_check
      $error("hsr_pulse_qual: MIN_CYC must be at least 1");
   end

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic          next_qualified;

   always_comb begin
      next_count     = '0;
      next_qualified = 1'b0;
      if (active) begin
         next_qualified = (count == LAST);
         next_count     = (count == LAST) ? count : CW'(count + 1'b1);
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count     <= '0;
         qualified <= 1'b0;
      end else begin
         count     <= next_count;
         qualified <= next_qualified;
      end
   end

endmodule // hsr_pulse_qual

/* hdl/hsr_hotswap_ctrl.sv */
/*
 * Supervisory logic of a hot-swap controller: gate shutdown on voltage and
 * current faults, overcurrent retry with failure flag, power good, delayed
 * system reset release and an AXI4-Lite register slave.
 * Assumes comparator and select inputs synchronous to clock; the manual reset
 * pins are resynchronised here.
 */
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`include "hsr_defines.svh"

module hsr_hotswap_ctrl #(
   parameter int       RETRY_DELAY_CYCLES  = `HSR_RETRY_DELAY_CYC,
   parameter int       MIN_PULSE_CYCLES    = `HSR_MIN_PULSE_CYC,
   parameter int       OC_FILTER_CYCLES    = `HSR_OC_FILTER_CYC,
   parameter bit [2:0] RETRY_LIMIT_DEFAULT = `HSR_RETRY_LIMIT_DEF
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 reset_n,
   // Register bus
   input  wire hsr_pkg::hsr_axi_req_s axi_req,
   output hsr_pkg::hsr_axi_rsp_s      axi_rsp,
   // Comparator results, high while the fault condition holds
   input  wire hsr_pkg::hsr_comp_s    comp,
   // Control inputs
   input  wire logic                 battery_supply_select_in,
   input  wire logic                 cold_side_manual_reset,
   input  wire logic                 hot_side_manual_reset_n,
   input  wire logic                 gate_current_sel_hi,
   input  wire logic                 gate_current_sel_lo,
   input  wire logic                 sequencing_done,
   // Outputs
   output logic                      gate_drive_on,
   output hsr_pkg::hsr_igate_e       gate_current,
   output logic                      power_good_out,
   output logic                      system_reset_n,
   output logic                      retry_failure_flag
);
   import hsr_pkg::*;

   localparam int RTW = $clog2(RETRY_DELAY_CYCLES + 1);
   localparam logic [RTW-1:0] RETRY_LAST = RTW'(RETRY_DELAY_CYCLES - 1);

   if (RETRY_DELAY_CYCLES < 2 || MIN_PULSE_CYCLES < 1 || OC_FILTER_CYCLES < 1)
   begin : g_check
      $error("hsr_hotswap_ctrl: timing counts out of range");
   end

   // Manual reset qualification
   logic [1:0] mr_sync;
   logic       mrc_active;
   logic       mrh_active;
   logic       oc_filtered;

   hsr_sync #(
      .WIDTH (2)
   ) u_mr_sync (
      .clock   (clock),
      .reset_n (reset_n),
      .d       ({cold_side_manual_reset, ~hot_side_manual_reset_n}),
      .q       (mr_sync)
   );

   hsr_pulse_qual #(
      .MIN_CYC (MIN_PULSE_CYCLES)
   ) u_mrc_qual (
      .clock     (clock),
      .reset_n   (reset_n),
      .active    (mr_sync[1]),
      .qualified (mrc_active)
   );

   hsr_pulse_qual #(
      .MIN_CYC (MIN_PULSE_CYCLES)
   ) u_mrh_qual (
      .clock     (clock),
      .reset_n   (reset_n),
      .active    (mr_sync[0]),
      .qualified (mrh_active)
   );

   // Overcurrent noise filter
   hsr_pulse_qual #(
      .MIN_CYC (OC_FILTER_CYCLES)
   ) u_oc_qual (
      .clock     (clock),
      .reset_n   (reset_n),
      .active    (comp.overcurrent_trip),
      .qualified (oc_filtered)
   );

   // Software-written settings
   logic [15:0] reset_delay;
   logic [2:0]  retry_limit;

   // Gate control
   hsr_gate_state_e gate_state;
   hsr_gate_state_e next_gate_state;
   logic [RTW-1:0]  retry_timer;
   logic [RTW-1:0]  next_retry_timer;
   logic [2:0]      retry_count;
   logic [2:0]      next_retry_count;
   logic            uv_fault;
   logic            hard_off;
   logic            next_gate_drive_on;
   logic            next_power_good_out;
   logic            next_retry_failure_flag;
   hsr_igate_e      next_gate_current;

   // Unselected undervoltage trip is ignored; select acts combinationally
   assign uv_fault = battery_supply_select_in ? comp.battery_undervoltage_trip
                                              : comp.mains_undervoltage_trip;
   // No filter on voltage faults: gate drops at the next edge
   assign hard_off = comp.overvoltage_trip | uv_fault | mrh_active;

   always_comb begin
      next_gate_state  = gate_state;
      next_retry_timer = retry_timer;
      next_retry_count = retry_count;
      unique case (gate_state)
         HSR_GATE_HOLD: begin
            next_retry_timer = '0;
            next_retry_count = '0;
            if (!hard_off && !oc_filtered) begin
               next_gate_state = HSR_GATE_ON;
            end
         end
         HSR_GATE_ON: begin
            if (hard_off) begin
               next_gate_state = HSR_GATE_HOLD;
            end else if (oc_filtered) begin
               next_retry_timer = '0;
               if (retry_limit != 3'h0 && retry_count == retry_limit) begin
                  next_gate_state = HSR_GATE_FAIL;
               end else begin
                  next_gate_state = HSR_GATE_WAIT;
               end
            end else if (retry_timer == RETRY_LAST) begin
               // A full retry period without a trip ends the fault episode
               next_retry_count = '0;
            end else begin
               next_retry_timer = RTW'(retry_timer + 1'b1);
            end
         end
         HSR_GATE_WAIT: begin
            if (hard_off) begin
               next_gate_state = HSR_GATE_HOLD;
            end else if (retry_timer == RETRY_LAST) begin
               next_retry_timer = '0;
               next_retry_count = 3'(retry_count + 1'b1);
               next_gate_state  = HSR_GATE_ON;
            end else begin
               next_retry_timer = RTW'(retry_timer + 1'b1);
            end
         end
         HSR_GATE_FAIL: begin
            if (mrh_active) begin
               next_gate_state = HSR_GATE_HOLD;
            end
         end
      endcase
      next_gate_drive_on      = (next_gate_state == HSR_GATE_ON);
      next_power_good_out     = (next_gate_state == HSR_GATE_ON);
      next_retry_failure_flag = (next_gate_state == HSR_GATE_FAIL);
      next_gate_current = hsr_igate_e'({gate_current_sel_hi, gate_current_sel_lo});
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gate_state         <= HSR_GATE_HOLD;
         retry_timer        <= '0;
         retry_count        <= 3'h0;
         gate_drive_on      <= 1'b0;
         power_good_out     <= 1'b0;
         retry_failure_flag <= 1'b0;
         gate_current       <= HSR_IGATE_50UA;
      end else begin
         gate_state         <= next_gate_state;
         retry_timer        <= next_retry_timer;
         retry_count        <= next_retry_count;
         gate_drive_on      <= next_gate_drive_on;
         power_good_out     <= next_power_good_out;
         retry_failure_flag <= next_retry_failure_flag;
         gate_current       <= next_gate_current;
      end
   end

   // System reset release
   logic [15:0] reset_count;
   logic [15:0] next_reset_count;
   logic        next_system_reset_n;

   always_comb begin
      next_reset_count    = reset_count;
      next_system_reset_n = 1'b0;
      if (mrc_active || !power_good_out || !sequencing_done) begin
         next_reset_count = 16'h0000;
      end else if (reset_count < reset_delay) begin
         next_reset_count = 16'(reset_count + 1'b1);
      end else begin
         next_system_reset_n = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reset_count    <= 16'h0000;
         system_reset_n <= 1'b0;
      end else begin
         reset_count    <= next_reset_count;
         system_reset_n <= next_system_reset_n;
      end
   end

   // AXI4-Lite slave, one write and one read in flight
   hsr_axi_rsp_s next_axi_rsp;
   logic         aw_held;
   logic         w_held;
   logic         next_aw_held;
   logic         next_w_held;
   logic [31:0]  awaddr_q;
   logic [31:0]  next_awaddr_q;
   logic [31:0]  wdata_q;
   logic [31:0]  next_wdata_q;
   logic [3:0]   wstrb_q;
   logic [3:0]   next_wstrb_q;
   logic [15:0]  next_reset_delay;
   logic [2:0]   next_retry_limit;
   logic [31:0]  status_word;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`HSR_ST_GATE]        = gate_drive_on;
      status_word[`HSR_ST_PWR_GOOD]    = power_good_out;
      status_word[`HSR_ST_SYS_RESET_N] = system_reset_n;
      status_word[`HSR_ST_FAILURE]     = retry_failure_flag;
      status_word[`HSR_ST_BATT_SEL]    = battery_supply_select_in;
      status_word[`HSR_ST_OV]          = comp.overvoltage_trip;
      status_word[`HSR_ST_UV]          = uv_fault;
      status_word[`HSR_ST_OC]          = oc_filtered;
      status_word[`HSR_ST_IGATE_LSB +: 2] = gate_current;
      status_word[`HSR_ST_RETRY_LSB +: 3] = retry_count;
      status_word[`HSR_ST_STATE_LSB +: 4] = gate_state;
   end

   always_comb begin
      next_axi_rsp     = axi_rsp;
      next_aw_held     = aw_held;
      next_w_held      = w_held;
      next_awaddr_q    = awaddr_q;
      next_wdata_q     = wdata_q;
      next_wstrb_q     = wstrb_q;
      next_reset_delay = reset_delay;
      next_retry_limit = retry_limit;
      if (axi_req.awvalid && axi_rsp.awready) begin
         next_aw_held         = 1'b1;
         next_awaddr_q        = axi_req.awaddr;
         next_axi_rsp.awready = 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
         next_w_held         = 1'b1;
         next_wdata_q        = axi_req.wdata;
         next_wstrb_q        = axi_req.wstrb;
         next_axi_rsp.wready = 1'b0;
      end
      if (aw_held && w_held) begin
         next_aw_held        = 1'b0;
         next_w_held         = 1'b0;
         next_axi_rsp.bvalid = 1'b1;
         next_axi_rsp.bresp  = `HSR_RESP_OKAY;
         if (awaddr_q == `HSR_REG_RESET_DELAY) begin
            if (wstrb_q[0]) next_reset_delay[7:0]  = wdata_q[7:0];
            if (wstrb_q[1]) next_reset_delay[15:8] = wdata_q[15:8];
         end else if (awaddr_q == `HSR_REG_RETRY_LIMIT) begin
            if (wstrb_q[0]) next_retry_limit = wdata_q[2:0];
         end else if (awaddr_q != `HSR_REG_STATUS) begin
            next_axi_rsp.bresp = `HSR_RESP_SLVERR;
         end
      end
      if (axi_rsp.bvalid && axi_req.bready) begin
         next_axi_rsp.bvalid  = 1'b0;
         next_axi_rsp.awready = 1'b1;
         next_axi_rsp.wready  = 1'b1;
      end
      if (axi_req.arvalid && axi_rsp.arready) begin
         next_axi_rsp.arready = 1'b0;
         next_axi_rsp.rvalid  = 1'b1;
         next_axi_rsp.rresp   = `HSR_RESP_OKAY;
         unique case (axi_req.araddr)
            `HSR_REG_RESET_DELAY: next_axi_rsp.rdata = {16'h0000, reset_delay};
            `HSR_REG_RETRY_LIMIT: next_axi_rsp.rdata = {29'h0000_0000, retry_limit};
            `HSR_REG_STATUS:      next_axi_rsp.rdata = status_word;
            default: begin
               next_axi_rsp.rdata = 32'h0000_0000;
               next_axi_rsp.rresp = `HSR_RESP_SLVERR;
            end
         endcase
      end
      if (axi_rsp.rvalid && axi_req.rready) begin
         next_axi_rsp.rvalid  = 1'b0;
         next_axi_rsp.arready = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         axi_rsp     <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
         aw_held     <= 1'b0;
         w_held      <= 1'b0;
         awaddr_q    <= 32'h0000_0000;
         wdata_q     <= 32'h0000_0000;
         wstrb_q     <= 4'h0;
         reset_delay <= `HSR_RESET_DELAY_DEF;
         retry_limit <= RETRY_LIMIT_DEFAULT;
      end else begin
         axi_rsp     <= next_axi_rsp;
         aw_held     <= next_aw_held;
         w_held      <= next_w_held;
         awaddr_q    <= next_awaddr_q;
         wdata_q     <= next_wdata_q;
         wstrb_q     <= next_wstrb_q;
         reset_delay <= next_reset_delay;
         retry_limit <= next_retry_limit;
      end
   end

endmodule // hsr_hotswap_ctrl

/* bench/hsr_power_module_model.sv */
/*
 * Behavioural model of the downstream power modules and their sequencer.
 * Assumes power_good_out is the modules' enable; reports completion
 * SEQ_CYCLES + 1 clocks after it rises.
 */
module hsr_power_module_model #(
   parameter int SEQ_CYCLES = 4
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // Enable in, completion out
   input  wire logic power_good_out,
   output logic      sequencing_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] ramp_cnt;

   // Modules ramp only while enabled and drop completion when disabled
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ramp_cnt        <= 8'h00;
         sequencing_done <= 1'b0;
      end else if (!power_good_out) begin
         ramp_cnt        <= 8'h00;
         sequencing_done <= 1'b0;
      end else begin
         if (ramp_cnt != 8'(SEQ_CYCLES)) ramp_cnt <= ramp_cnt + 8'h01;
         sequencing_done <= (ramp_cnt == 8'(SEQ_CYCLES));
      end
   end
endmodule // hsr_power_module_model

/* bench/hsr_hotswap_ctrl_properties.sv */
/*
 * Checker of the hot-swap controller: gate, power good, system reset and
 * failure flag relations at the top module's ports.
 * Assumes it is bound to hsr_hotswap_ctrl with matching counts.
 */
module hsr_hotswap_ctrl_chk #(
   parameter int MIN_PULSE_CYCLES = 50,
   parameter int OC_FILTER_CYCLES = 50
) (
   // Clock and reset
   input wire logic                  clock,
   input wire logic                  reset_n,
   // Register bus
   input wire hsr_pkg::hsr_axi_req_s axi_req,
   input wire hsr_pkg::hsr_axi_rsp_s axi_rsp,
   // Fault and control inputs
   input wire hsr_pkg::hsr_comp_s    comp,
   input wire logic                  battery_supply_select_in,
   input wire logic                  cold_side_manual_reset,
   input wire logic                  hot_side_manual_reset_n,
   input wire logic                  gate_current_sel_hi,
   input wire logic                  gate_current_sel_lo,
   input wire logic                  sequencing_done,
   // Outputs
   input wire logic                  gate_drive_on,
   input wire hsr_pkg::hsr_igate_e   gate_current,
   input wire logic                  power_good_out,
   input wire logic                  system_reset_n,
   input wire logic                  retry_failure_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   import hsr_pkg::*;
   logic [7:0] hot_cnt, cold_cnt, oc_cnt;
   logic [7:0] next_hot_cnt, next_cold_cnt, next_oc_cnt;

   // Saturating counts of consecutive active cycles on each slow input
   always_comb begin
      next_hot_cnt  = hot_side_manual_reset_n ? 8'h00 : hot_cnt + 8'(hot_cnt != 8'hFF);
      next_cold_cnt = !cold_side_manual_reset ? 8'h00 : cold_cnt + 8'(cold_cnt != 8'hFF);
      next_oc_cnt   = !comp.overcurrent_trip ? 8'h00 : oc_cnt + 8'(oc_cnt != 8'hFF);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         hot_cnt  <= 8'h00;
         cold_cnt <= 8'h00;
         oc_cnt   <= 8'h00;
      end else begin
         hot_cnt  <= next_hot_cnt;
         cold_cnt <= next_cold_cnt;
         oc_cnt   <= next_oc_cnt;
      end
   end

   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   chk_ov_gate_off: assert property (
      comp.overvoltage_trip |=> !gate_drive_on) else $error("gate on in overvoltage");
   chk_uv_selected: assert property (
      (battery_supply_select_in ? comp.battery_undervoltage_trip : comp.mains_undervoltage_trip)
      |=> !gate_drive_on) else $error("gate on in selected undervoltage");
   chk_pg_follows_gate: assert property (
      power_good_out == gate_drive_on) else $error("power good differs from gate");
   chk_reset_held: assert property (
      (!power_good_out || !sequencing_done) [*2] |=> !system_reset_n)
      else $error("system reset released early");
   chk_reset_cause: assert property (
      $rose(system_reset_n) |-> $past(power_good_out, 2) && $past(sequencing_done, 2))
      else $error("system reset rose without cause");
   chk_igate_copy: assert property (
      $past(reset_n) |-> gate_current == $past({gate_current_sel_hi, gate_current_sel_lo}))
      else $error("gate current code wrong");
   chk_fail_gate_off: assert property (
      retry_failure_flag |-> !gate_drive_on && !power_good_out)
      else $error("gate on with failure flag");
   chk_hot_reset: assert property (
      hot_cnt >= 8'(MIN_PULSE_CYCLES + 4) |-> !gate_drive_on && !retry_failure_flag)
      else $error("hot-side reset ignored");
   chk_cold_reset: assert property (
      cold_cnt >= 8'(MIN_PULSE_CYCLES + 4) |-> !system_reset_n)
      else $error("cold-side reset ignored");
   chk_oc_gate_off: assert property (
      oc_cnt == 8'(OC_FILTER_CYCLES + 2) |-> !gate_drive_on) else $error("gate on in overcurrent");

   cov_fail_flag: cover property ($rose(retry_failure_flag));
   cov_reset_release: cover property ($rose(system_reset_n));
   cov_ov_trip: cover property (comp.overvoltage_trip ##1 !gate_drive_on);
endmodule // hsr_hotswap_ctrl_chk

bind hsr_hotswap_ctrl hsr_hotswap_ctrl_chk #(
   .MIN_PULSE_CYCLES(MIN_PULSE_CYCLES),
   .OC_FILTER_CYCLES(OC_FILTER_CYCLES)
) u_chk (
   .clock(clock), .reset_n(reset_n), .axi_req(axi_req), .axi_rsp(axi_rsp), .comp(comp),
   .battery_supply_select_in(battery_supply_select_in),
   .cold_side_manual_reset(cold_side_manual_reset),
   .hot_side_manual_reset_n(hot_side_manual_reset_n),
   .gate_current_sel_hi(gate_current_sel_hi), .gate_current_sel_lo(gate_current_sel_lo),
   .sequencing_done(sequencing_done), .gate_drive_on(gate_drive_on),
   .gate_current(gate_current), .power_good_out(power_good_out),
   .system_reset_n(system_reset_n), .retry_failure_flag(retry_failure_flag)
);

/* bench/hsr_hotswap_ctrl_tb.sv */
/*
 * Self-checking bench of the hot-swap controller over its pins and register bus.
 * Assumes the power module model on the far side and shortened counts.
 */
`include "hsr_defines.svh"

module hsr_hotswap_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import hsr_pkg::*;
   localparam int RETRY_CYC = 20;
   localparam int OC_CYC    = 4;
   localparam int MIN_CYC   = 50;
   logic         clock, reset_n, batt, cold, hot_n, sel_hi, sel_lo, seq_done;
   logic         gate_on, pg, sys_rst_n, fail_flag;
   hsr_axi_req_s req;
   hsr_axi_rsp_s rsp;
   hsr_comp_s    comp;
   hsr_igate_e   igate;
   int           error_cnt, check_count, n;

   hsr_hotswap_ctrl #(.RETRY_DELAY_CYCLES(RETRY_CYC), .OC_FILTER_CYCLES(OC_CYC)) u_dut (
      .clock(clock), .reset_n(reset_n), .axi_req(req), .axi_rsp(rsp), .comp(comp),
      .battery_supply_select_in(batt), .cold_side_manual_reset(cold),
      .hot_side_manual_reset_n(hot_n), .gate_current_sel_hi(sel_hi),
      .gate_current_sel_lo(sel_lo), .sequencing_done(seq_done), .gate_drive_on(gate_on),
      .gate_current(igate), .power_good_out(pg), .system_reset_n(sys_rst_n),
      .retry_failure_flag(fail_flag));

   hsr_power_module_model u_mod (
      .clock(clock), .reset_n(reset_n), .power_good_out(pg), .sequencing_done(seq_done));

   task automatic results();
      if (error_cnt == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic guard(input int cnt);
      if (cnt >= 400) begin
         error_cnt++;
         results();
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
   endtask

   task automatic flags(input logic [2:0] e);
      chk("gate_pg_fail", 32'({gate_on, pg, fail_flag}), 32'(e));
   endtask

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      k = 0;
      req.awaddr  <= a;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      do begin
         @(posedge clock);
         k++;
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid && k < 400);
      guard(k);
      chk("bresp", 32'(rsp.bresp), 32'(er));
   endtask

   task automatic axi_rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
      int k;
      k = 0;
      req.araddr  <= a;
      req.arvalid <= 1'b1;
      do begin
         @(posedge clock);
         k++;
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid && k < 400);
      guard(k);
      chk("rdata", rsp.rdata, e);
      chk("rresp", 32'(rsp.rresp), 32'(er));
   endtask

   task automatic wait_release();
      n = 0;
      while (sys_rst_n !== 1'b1 && n < 400) begin
         cyc(1);
         n++;
      end
      guard(n);
   endtask

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      {reset_n, batt, cold, sel_hi, sel_lo} = 5'h00;
      hot_n = 1'b1;
      comp = '0;
      req = '0;
      req.bready = 1'b1;
      req.rready = 1'b1;
      error_cnt = 0;
      check_count = 0;
      cyc(5);
      reset_n <= 1'b1;
      cyc(3);
      axi_rd(`HSR_REG_RESET_DELAY, 32'(`HSR_RESET_DELAY_DEF), `HSR_RESP_OKAY);
      axi_rd(`HSR_REG_RETRY_LIMIT, 32'h0000_0005, `HSR_RESP_OKAY);
      axi_rd(`HSR_REG_STATUS, 32'h0002_0003, `HSR_RESP_OKAY);
      axi_wr(`HSR_REG_STATUS, 32'hFFFF_FFFF, `HSR_RESP_OKAY);
      axi_rd(`HSR_REG_STATUS, 32'h0002_0003, `HSR_RESP_OKAY);
      axi_wr(32'h0000_000C, 32'h0000_0001, `HSR_RESP_SLVERR);
      axi_rd(32'h0000_000C, 32'h0000_0000, `HSR_RESP_SLVERR);
      axi_wr(`HSR_REG_RESET_DELAY, 32'h0000_0003, `HSR_RESP_OKAY);
      axi_rd(`HSR_REG_RESET_DELAY, 32'h0000_0003, `HSR_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         {sel_hi, sel_lo} <= 2'(i);
         cyc(2);
         chk("igate", 32'(igate), 32'(i));
      end
      cold <= 1'b1;
      cyc(MIN_CYC + 6);
      chk("sys_rst_n", 32'(sys_rst_n), 32'h0);
      cold <= 1'b0;
      cyc(3);
      chk("sys_rst_n", 32'(sys_rst_n), 32'h0);
      wait_release();
      comp.overvoltage_trip <= 1'b1;
      cyc(2);
      flags(3'b000);
      cyc(2);
      chk("sys_rst_n", 32'(sys_rst_n), 32'h0);
      comp.overvoltage_trip <= 1'b0;
      cyc(4);
      flags(3'b110);
      chk("sys_rst_n", 32'(sys_rst_n), 32'h0);
      wait_release();
      for (int i = 0; i < 4; i++) begin
         batt <= i[1];
         comp.mains_undervoltage_trip <= !i[0];
         comp.battery_undervoltage_trip <= i[0];
         cyc(2);
         flags({i[1] != i[0], i[1] != i[0], 1'b0});
         comp.mains_undervoltage_trip <= 1'b0;
         comp.battery_undervoltage_trip <= 1'b0;
         cyc(4);
      end
      batt <= 1'b0;
      comp.battery_undervoltage_trip <= 1'b1;
      cyc(2);
      flags(3'b110);
      batt <= 1'b1;
      cyc(2);
      flags(3'b000);
      comp.battery_undervoltage_trip <= 1'b0;
      cyc(4);
      hot_n <= 1'b0;
      cyc(20);
      hot_n <= 1'b1;
      cyc(5);
      flags(3'b110);
      axi_wr(`HSR_REG_RETRY_LIMIT, 32'h0000_0002, `HSR_RESP_OKAY);
      comp.overcurrent_trip <= 1'b1;
      n = 0;
      while (fail_flag !== 1'b1 && n < 400) begin
         cyc(1);
         n++;
      end
      guard(n);
      chk("retry_span", 32'(n >= 2 * RETRY_CYC && n <= 3 * (RETRY_CYC + OC_CYC + 4)), 32'h1);
      flags(3'b001);
      comp.overcurrent_trip <= 1'b0;
      cyc(RETRY_CYC + 5);
      flags(3'b001);
      hot_n <= 1'b0;
      cyc(MIN_CYC + 6);
      flags(3'b000);
      hot_n <= 1'b1;
      cyc(8);
      flags(3'b110);
      axi_wr(`HSR_REG_RETRY_LIMIT, 32'h0000_0000, `HSR_RESP_OKAY);
      comp.overcurrent_trip <= 1'b1;
      cyc(4 * RETRY_CYC);
      chk("fail_flag", 32'(fail_flag), 32'h0);
      comp.overcurrent_trip <= 1'b0;
      cyc(RETRY_CYC + 8);
      flags(3'b110);
      results();
   end
endmodule // hsr_hotswap_ctrl_tb
